// [rtl/rivp_consts.vh]
// Constants for the reset and interrupt vector placement block.
// Assumes a 20 MHz system clock and word-addressed program memory.
// What this block does
// - Any reset starts at address zero normally
// - External requests 0,1,2 map to 002,004,024
// - Timer sources map to their fixed slots
// - Serial and USART sources map 014..01A
// - Converter, data memory, comparator, two-wire 01C..022
// - Program store ready maps to 028, last
// - Programmed boot fuse starts at boot address
// - Vector select adds boot section start address
// - Fuse and select pick reset and vector base
// - Change enable, then select write within four
// - Block interrupts during change, flag untouched
`ifndef RIVP_CONSTS_VH
`define RIVP_CONSTS_VH
`define RIVP_AW          14
`define RIVP_NSRC        20
`define RIVP_SRCW        5
`define RIVP_RESET_ADDR  14'h0000
`define RIVP_VEC_START   14'h0002
`define RIVP_SLOT_WORDS  14'h0002
`define RIVP_CHG_CYCLES  3'h4
`define RIVP_CNTW        3
`define RIVP_CNT_ZERO    3'h0
`define RIVP_CNT_LAST    3'h1
`define RIVP_CNT_STEP    3'h1
`define RIVP_SRC_IDLE    5'h00
// Source indices, priority order (lowest index wins)
`define RIVP_S_EXT0      5'h00
`define RIVP_S_EXT1      5'h01
`define RIVP_S_T2CMP     5'h02
`define RIVP_S_T2OVF     5'h03
`define RIVP_S_T1CAP     5'h04
`define RIVP_S_T1CMPA    5'h05
`define RIVP_S_T1CMPB    5'h06
`define RIVP_S_T1OVF     5'h07
`define RIVP_S_T0OVF     5'h08
`define RIVP_S_SER_DONE  5'h09
`define RIVP_S_RX_DONE   5'h0A
`define RIVP_S_TX_EMPTY  5'h0B
`define RIVP_S_TX_DONE   5'h0C
`define RIVP_S_ADC       5'h0D
`define RIVP_S_NVM       5'h0E
`define RIVP_S_ACMP      5'h0F
`define RIVP_S_TWO_WIRE  5'h10
`define RIVP_S_EXT2      5'h11
`define RIVP_S_T0CMP     5'h12
`define RIVP_S_PSTORE    5'h13
// Slot per source; reset owns slot zero
`define RIVP_SLOT_EXT0      14'h0001
`define RIVP_SLOT_EXT1      14'h0002
`define RIVP_SLOT_T2CMP     14'h0003
`define RIVP_SLOT_T2OVF     14'h0004
`define RIVP_SLOT_T1CAP     14'h0005
`define RIVP_SLOT_T1CMPA    14'h0006
`define RIVP_SLOT_T1CMPB    14'h0007
`define RIVP_SLOT_T1OVF     14'h0008
`define RIVP_SLOT_T0OVF     14'h0009
`define RIVP_SLOT_SER_DONE  14'h000A
`define RIVP_SLOT_RX_DONE   14'h000B
`define RIVP_SLOT_TX_EMPTY  14'h000C
`define RIVP_SLOT_TX_DONE   14'h000D
`define RIVP_SLOT_ADC       14'h000E
`define RIVP_SLOT_NVM       14'h000F
`define RIVP_SLOT_ACMP      14'h0010
`define RIVP_SLOT_TWO_WIRE  14'h0011
`define RIVP_SLOT_EXT2      14'h0012
`define RIVP_SLOT_T0CMP     14'h0013
`define RIVP_SLOT_PSTORE    14'h0014
`endif

// [rtl/rivp_vector_place.v]
// Reset address and interrupt vector address generator with guarded table move.
// Assumes request levels from on-chip logic on clock_i and a fuse/boot address
// that are static after reset.
// Fuse and boot address pass no synchroniser: a change while running
// gives a valid address only from the next fetch on.
// Vector address lags the request levels by one clock.
`timescale 1ns/10ps
`default_nettype none
`include "rivp_consts.vh"
module rivp_vector_place (
   input  wire                        clock_i,
   input  wire                        rstn_i,
   input  wire                        boot_reset_select_fuse_i,
   input  wire [`RIVP_AW-1:0]         boot_reset_addr_i,
   input  wire [`RIVP_NSRC-1:0]       irq_req_i,
   input  wire                        global_irq_enable_i,
   input  wire                        ctrl_wr_i,
   input  wire                        wr_vector_table_select_i,
   input  wire                        wr_vector_change_enable_i,
   input  wire                        instr_done_i,
   output wire [`RIVP_AW-1:0]         reset_addr_o,
   output reg  [`RIVP_AW-1:0]         vector_addr_o,
   output reg  [`RIVP_SRCW-1:0]       vector_src_o,
   output wire                        irq_take_o,
   output wire                        irq_blocked_o,
   output wire                        vector_table_select_o,
   output wire                        vector_change_enable_o
);

////////////////////////////////////////////////////////////////////////////////
// Slot number per source; reset occupies slot 0
function [`RIVP_AW-1:0] rivp_slot;
   input [`RIVP_SRCW-1:0] src;
   begin
      case (src)
         // External requests
         `RIVP_S_EXT0:     rivp_slot = `RIVP_SLOT_EXT0;
         `RIVP_S_EXT1:     rivp_slot = `RIVP_SLOT_EXT1;
         `RIVP_S_EXT2:     rivp_slot = `RIVP_SLOT_EXT2;
         // Timers
         `RIVP_S_T2CMP:    rivp_slot = `RIVP_SLOT_T2CMP;
         `RIVP_S_T2OVF:    rivp_slot = `RIVP_SLOT_T2OVF;
         `RIVP_S_T1CAP:    rivp_slot = `RIVP_SLOT_T1CAP;
         `RIVP_S_T1CMPA:   rivp_slot = `RIVP_SLOT_T1CMPA;
         `RIVP_S_T1CMPB:   rivp_slot = `RIVP_SLOT_T1CMPB;
         `RIVP_S_T1OVF:    rivp_slot = `RIVP_SLOT_T1OVF;
         `RIVP_S_T0OVF:    rivp_slot = `RIVP_SLOT_T0OVF;
         `RIVP_S_T0CMP:    rivp_slot = `RIVP_SLOT_T0CMP;
         // Serial sources
         `RIVP_S_SER_DONE: rivp_slot = `RIVP_SLOT_SER_DONE;
         `RIVP_S_RX_DONE:  rivp_slot = `RIVP_SLOT_RX_DONE;
         `RIVP_S_TX_EMPTY: rivp_slot = `RIVP_SLOT_TX_EMPTY;
         `RIVP_S_TX_DONE:  rivp_slot = `RIVP_SLOT_TX_DONE;
         // Converter, data memory, comparator, two-wire
         `RIVP_S_ADC:      rivp_slot = `RIVP_SLOT_ADC;
         `RIVP_S_NVM:      rivp_slot = `RIVP_SLOT_NVM;
         `RIVP_S_ACMP:     rivp_slot = `RIVP_SLOT_ACMP;
         `RIVP_S_TWO_WIRE: rivp_slot = `RIVP_SLOT_TWO_WIRE;
         // Program store, last slot
         `RIVP_S_PSTORE:   rivp_slot = `RIVP_SLOT_PSTORE;
         default:          rivp_slot = `RIVP_SLOT_PSTORE;
      endcase
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Fixed priority: lowest index wins, as in the table order.
// With no request the last source is picked; nobody fetches it then.
function [`RIVP_SRCW-1:0] rivp_pick;
   input [`RIVP_NSRC-1:0] req;
   integer                k;
   begin
      rivp_pick = `RIVP_S_PSTORE;
      for (k = `RIVP_NSRC-1; k >= 0; k = k - 1) begin
         if (req[k]) begin
            rivp_pick = k[`RIVP_SRCW-1:0];
         end
      end
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Boot section start or address zero; shared by reset and vector table
function [`RIVP_AW-1:0] rivp_base;
   input                  use_boot;
   input [`RIVP_AW-1:0]   boot;
   begin
      if (use_boot) begin
         rivp_base = boot;
      end else begin
         rivp_base = `RIVP_RESET_ADDR;
      end
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
reg                    sel_reg;
reg                    sel_next;
reg                    chg_reg;
reg                    chg_next;
reg [`RIVP_CNTW-1:0]   cnt_reg;
reg [`RIVP_CNTW-1:0]   cnt_next;
reg                    hold_reg;
reg                    hold_next;
wire                   sel_write;
wire [`RIVP_AW-1:0]    base;
wire                   arm_write;
wire                   cnt_expire;
wire                   any_req;
wire [`RIVP_SRCW-1:0]  win;
reg  [`RIVP_AW-1:0]    vec_next;
reg  [`RIVP_SRCW-1:0]  src_next;

// Select may change only while enable is open and enable is written zero
assign sel_write = ctrl_wr_i && chg_reg && !wr_vector_change_enable_i;

assign arm_write  = ctrl_wr_i && wr_vector_change_enable_i;
assign cnt_expire = chg_reg && (cnt_reg == `RIVP_CNT_LAST);

////////////////////////////////////////////////////////////////////////////////
always @* begin
   sel_next = sel_reg;
   if (sel_write) begin
      sel_next = wr_vector_table_select_i;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Re-arming restarts the window; a select write closes it at once
always @* begin
   chg_next = chg_reg;
   cnt_next = cnt_reg;
   if (sel_write) begin
      chg_next = 1'b0;
      cnt_next = `RIVP_CNT_ZERO;
   end else if (arm_write) begin
      chg_next = 1'b1;
      cnt_next = `RIVP_CHG_CYCLES;
   end else if (chg_reg) begin
      cnt_next = cnt_reg - `RIVP_CNT_STEP;
      if (cnt_expire) begin
         chg_next = 1'b0;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Set wins when the select write and a retiring instruction coincide
always @* begin
   hold_next = hold_reg;
   if (sel_write) begin
      hold_next = 1'b1;
   end else if (hold_reg && instr_done_i) begin
      hold_next = 1'b0;
   end
end

always @(posedge clock_i or negedge rstn_i) begin
   if (!rstn_i) begin
      sel_reg  <= 1'b0;
      hold_reg <= 1'b0;
   end else begin
      sel_reg  <= sel_next;
      hold_reg <= hold_next;
   end
end

always @(posedge clock_i or negedge rstn_i) begin
   if (!rstn_i) begin
      chg_reg <= 1'b0;
      cnt_reg <= `RIVP_CNT_ZERO;
   end else begin
      chg_reg <= chg_next;
      cnt_reg <= cnt_next;
   end
end

assign vector_table_select_o  = sel_reg;
assign vector_change_enable_o = chg_reg;

// Blocking leaves the global enable itself untouched
assign irq_blocked_o = chg_reg || hold_reg;

////////////////////////////////////////////////////////////////////////////////
// Fuse low means programmed: start in the boot section
assign reset_addr_o = rivp_base(!boot_reset_select_fuse_i, boot_reset_addr_i);

assign base = rivp_base(sel_reg, boot_reset_addr_i);

assign any_req = |irq_req_i;

// Global enable is only read here, never written back
assign irq_take_o = global_irq_enable_i && !irq_blocked_o && any_req;

////////////////////////////////////////////////////////////////////////////////
// Winning request and its address in the active table
assign win = rivp_pick(irq_req_i);

always @* begin
   src_next = win;
   vec_next = base + rivp_slot(win) * `RIVP_SLOT_WORDS;
end

// Registered so the vector address is stable for the fetch stage
always @(posedge clock_i or negedge rstn_i) begin
   if (!rstn_i) begin
      vector_addr_o <= `RIVP_VEC_START;
   end else begin
      vector_addr_o <= vec_next;
   end
end

// Source index kept in step with the address
always @(posedge clock_i or negedge rstn_i) begin
   if (!rstn_i) begin
      vector_src_o <= `RIVP_SRC_IDLE;
   end else begin
      vector_src_o <= src_next;
   end
end

endmodule
`default_nettype wire

// [dv/rivp_monitor.sv]
// Port checker for the vector block.
// Bound to every instance; one clock, async low reset.
`timescale 1ns/10ps
`default_nettype none
module rivp_monitor (
   input wire logic clock_i, rstn_i, boot_reset_select_fuse_i, global_irq_enable_i, ctrl_wr_i,
   input wire logic instr_done_i, irq_take_o, irq_blocked_o, vector_table_select_o, vector_change_enable_o,
   input wire logic [13:0] boot_reset_addr_i, reset_addr_o, vector_addr_o,
   input wire logic [19:0] irq_req_i,
   input wire logic [4:0] vector_src_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   wire [13:0] base = vector_table_select_o ? boot_reset_addr_i : 14'h0000;
   a_reset_pick: assert property (reset_addr_o == (boot_reset_select_fuse_i ? 14'h0000 : boot_reset_addr_i))
      else $error("reset addr");
   a_vec_form: assert property (|$past(irq_req_i) |->
      vector_addr_o == $past(base) + 14'h0002 + {vector_src_o, 1'b0}) else $error("vector addr");
   a_lowest_win: assert property (|$past(irq_req_i) |->
      ($past(irq_req_i) & ((20'h2 << vector_src_o) - 20'h1)) == (20'h1 << vector_src_o)) else $error("winner");
   a_take_gate: assert property (irq_take_o == (global_irq_enable_i && !irq_blocked_o && |irq_req_i))
      else $error("take");
   a_arm_blocks: assert property ($rose(vector_change_enable_o) |-> irq_blocked_o && $past(ctrl_wr_i))
      else $error("arm");
   a_enable_drop: assert property ($rose(vector_change_enable_o) |-> ##4 !vector_change_enable_o)
      else $error("enable stays");
   a_sel_guard: assert property ($changed(vector_table_select_o) |-> $past(vector_change_enable_o && ctrl_wr_i))
      else $error("select moved");
   a_done_unblock: assert property (irq_blocked_o && !vector_change_enable_o && instr_done_i && !ctrl_wr_i |=>
      !irq_blocked_o) else $error("still blocked");
endmodule
bind rivp_vector_place rivp_monitor u_mon (.*);
`default_nettype wire

// [dv/rivp_cpu.sv]
// CPU side: retires one instruction a cycle, none while stalled.
// Shares the block clock.
`timescale 1ns/10ps
`default_nettype none
module rivp_cpu (
   input  wire logic clock_i,
   input  wire logic stall_i,
   output var  logic done_o = 1'b0
);
   always @(posedge clock_i) done_o <= #2 !stall_i;
endmodule
`default_nettype wire

// [dv/rivp_vector_place_test.sv]
// Bench for the vector block; CPU side is rivp_cpu.
// Expected vector addresses queue up for a watcher.
`timescale 1ns/10ps
`default_nettype none
module rivp_vector_place_test;
   logic clock_i = 0, rstn_i = 0, boot_reset_select_fuse_i = 1, global_irq_enable_i = 1, stall = 1;
   logic ctrl_wr_i = 0, wr_vector_table_select_i = 0, wr_vector_change_enable_i = 0, instr_done_i;
   logic irq_take_o, irq_blocked_o, vector_table_select_o, vector_change_enable_o;
   logic [13:0] boot_reset_addr_i, reset_addr_o, vector_addr_o, q[$];
   logic [19:0] irq_req_i = 0;
   logic [4:0] vector_src_o;
   int fails = 0, num_checks = 0;
   rivp_vector_place u_dut (.*);
   rivp_cpu u_cpu (.clock_i, .stall_i(stall), .done_o(instr_done_i));
   initial forever #25 clock_i = !clock_i;
   always @(posedge clock_i) if (q.size()) #1 chk(vector_addr_o, q.pop_front());
   task chk(input logic [13:0] g, x);
      num_checks++;
      if (g !== x) begin
         fails++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
      end
   endtask
   task st(input logic [3:0] x);
      chk({10'h0, irq_blocked_o, irq_take_o, vector_change_enable_o, vector_table_select_o}, {10'h0, x});
   endtask
   task tick(input int n);
      repeat (n) @(posedge clock_i);
      #2;
   endtask
   // Caller drops the strobe, so writes can run back to back
   task wctl(input logic s, c);
      ctrl_wr_i = 1;
      wr_vector_table_select_i = s;
      wr_vector_change_enable_i = c;
      tick(1);
   endtask
   task scan(input logic [13:0] b);
      logic [13:0] e;
      for (int i = 0; i < 20; i++) begin
         irq_req_i = 20'h1 << i;
         q.push_back(b + 14'(2 * i + 2));
         tick(1);
      end
      irq_req_i = 20'($urandom) | 20'h80000;
      for (int k = 19; k >= 0; k--)
         if (irq_req_i[k]) e = b + 14'(2 * k + 2);
      q.push_back(e);
      tick(1);
   endtask
   task print_verdict;
      if (fails == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      void'($urandom(86));
      boot_reset_addr_i = 14'($urandom);
      tick(12);
      rstn_i = 1;
      chk(reset_addr_o, 14'h0000);
      boot_reset_select_fuse_i = 0;
      #1 chk(reset_addr_o, boot_reset_addr_i);
      tick(1);
      scan(14'h0000);
      irq_req_i = 20'h1;
      wctl(1, 0);
      ctrl_wr_i = 0;
      st(4'b0100);
      wctl(0, 1);
      ctrl_wr_i = 0;
      st(4'b1010);
      tick(3);
      st(4'b1010);
      tick(1);
      st(4'b0100);
      wctl(0, 1);
      wctl(1, 0);
      ctrl_wr_i = 0;
      tick(2);
      st(4'b1001);
      stall = 0;
      tick(2);
      st(4'b0101);
      global_irq_enable_i = 0;
      tick(1);
      st(4'b0001);
      global_irq_enable_i = 1;
      scan(boot_reset_addr_i);
      print_verdict;
   end
   initial begin
      #100us;
      fails++;
      print_verdict;
   end
endmodule
`default_nettype wire
